// ==== treb_config.v ====
// Contract
// - Group 6/5 set code: keep, select, illegal.
// - Group 4/3 set code: keep, select, illegal.
// - Group 7/2/1 set code: keep, select, illegal.
// - Index register holds four bytes, reset 0x12.
// - Index maps to 18 dB minus index.
// - Bit 24 picks scaling or rate conversion.
// - Enable bit and two-bit sequence select.
// - IF select and decimal or binary tuning.
// - Decimal mode thousands, hundreds, tens, units digits.
// - Binary mode eleven-bit tuned frequency.
// - Channels 6/5 role follows configuration bit.
`timescale 1ns/1ps
`include "treb_map.vh"

module treb_config (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register access from the serial control port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [31:0] regRdData_q,
  output reg regRdValid_q,
  output reg regAddrMiss_q,
  // Channel configuration from the general control register
  input wire sixChannelMode,
  output reg surroundAsLineout_q,
  // Treble set selection per group, subwoofer group in the top slot
  output reg [11:0] trebleSet_q,
  output reg illegalSetWrite_q,
  // Treble gain per group
  output reg [31:0] trebleIndex_q,
  output reg [23:0] trebleGainDb_q,
  output reg [3:0] indexInvalid_q,
  // AM avoidance
  output reg amUseRateConv_q,
  output reg amEnable_q,
  output reg [1:0] amSequence_q,
  output reg amIfLow_q,
  output reg amBinaryTuned_q,
  output reg [15:0] amTunedField_q,
  output reg [10:0] amTunedKhz_q,
  output reg amDigitsValid_q
);

  wire wrSet;
  wire wrIndex;
  wire wrAm;
  wire mapped;
  wire [11:0] setSel;
  wire [3:0] setIllegal;
  wire [31:0] setReadback;
  wire [23:0] gainDb;
  wire [3:0] gainBad;

  reg [31:0] amReg_q;
  reg [31:0] amNext;
  reg [15:0] tunedNext;
  reg [10:0] khzNext;
  reg digitsOkNext;

  assign wrSet = regWrEn && (regAddr == `TREB_ADDR_SET);
  assign wrIndex = regWrEn && (regAddr == `TREB_ADDR_INDEX);
  assign wrAm = regWrEn && (regAddr == `TREB_ADDR_AM);
  assign mapped = (regAddr == `TREB_ADDR_SET) || (regAddr == `TREB_ADDR_INDEX) ||
    (regAddr == `TREB_ADDR_AM);

  // One selector and one gain mapper per channel group.
  genvar g;
  generate
    for (g = 0; g < `TREB_GROUPS; g = g + 1) begin : grp
      wire [7:0] idx;
      wire [7:0] clampIdx;

      // Reserved upper bits of each byte are dropped before the code is judged.
      treb_set_field setField (
        .clk(clk),
        .srst(srst),
        .wrEn(wrSet),
        .code(regWrData[g*`TREB_GROUP_W +: `TREB_SET_CODE_W]),
        .setSel_q(setSel[g*3 +: 3]),
        .illegal_q(setIllegal[g])
      );

      assign setReadback[g*`TREB_GROUP_W +: `TREB_GROUP_W] = {5'h00, setSel[g*3 +: 3]};

      assign idx = trebleIndex_q[g*`TREB_GROUP_W +: `TREB_GROUP_W];
      // Out-of-range indexes are clamped to the weakest gain rather than wrapped.
      assign gainBad[g] = (idx > `TREB_INDEX_MAX);
      assign clampIdx = gainBad[g] ? `TREB_INDEX_MAX : idx;
      assign gainDb[g*6 +: 6] = 6'h12 - clampIdx[5:0];
    end
  endgenerate

  // Next AM value: reserved bits cleared and the low half masked per tuning mode.
  always @* begin
    amNext = 32'h00000000;
    amNext[`TREB_AM_METHOD_BIT] = regWrData[`TREB_AM_METHOD_BIT];
    amNext[`TREB_AM_ENABLE_BIT] = regWrData[`TREB_AM_ENABLE_BIT];
    amNext[`TREB_AM_SEQ_HI:`TREB_AM_SEQ_LO] = regWrData[`TREB_AM_SEQ_HI:`TREB_AM_SEQ_LO];
    amNext[`TREB_AM_IF_BIT] = regWrData[`TREB_AM_IF_BIT];
    amNext[`TREB_AM_BINARY_BIT] = regWrData[`TREB_AM_BINARY_BIT];
    if (regWrData[`TREB_AM_BINARY_BIT]) begin
      amNext[15:0] = regWrData[15:0] & `TREB_AM_BIN_MASK;
    end else begin
      amNext[15:0] = regWrData[15:0] & `TREB_AM_BCD_MASK;
    end
  end

  // Tuned frequency in kHz, derived from the stored AM register.
  always @* begin
    tunedNext = amReg_q[15:0];
    khzNext = 11'h000;
    digitsOkNext = 1'b1;
    if (amReg_q[`TREB_AM_BINARY_BIT]) begin
      khzNext = tunedNext[`TREB_AM_BIN_HI:0];
    end else begin
      khzNext = (tunedNext[`TREB_AM_THOUSANDS_BIT] ? 11'h3E8 : 11'h000) +
        {7'h00, tunedNext[`TREB_AM_HUNDREDS_LO +: 4]} * 11'h064 +
        {7'h00, tunedNext[`TREB_AM_TENS_LO +: 4]} * 11'h00A +
        {7'h00, tunedNext[`TREB_AM_UNITS_LO +: 4]};
      digitsOkNext = (tunedNext[`TREB_AM_HUNDREDS_LO +: 4] <= `TREB_BCD_MAX_DIGIT) &&
        (tunedNext[`TREB_AM_TENS_LO +: 4] <= `TREB_BCD_MAX_DIGIT) &&
        (tunedNext[`TREB_AM_UNITS_LO +: 4] <= `TREB_BCD_MAX_DIGIT);
    end
  end

  // Register storage.
  always @(posedge clk) begin
    if (srst) begin
      trebleIndex_q <= `TREB_INDEX_RESET;
      amReg_q <= `TREB_AM_RESET;
    end else begin
      if (wrIndex) begin
        trebleIndex_q <= regWrData;
      end
      if (wrAm) begin
        amReg_q <= amNext;
      end
    end
  end

  // Read port answers one cycle after the strobe; unmapped reads return zero.
  always @(posedge clk) begin
    if (srst) begin
      regRdData_q <= 32'h00000000;
      regRdValid_q <= 1'b0;
      regAddrMiss_q <= 1'b0;
    end else begin
      regRdValid_q <= regRdEn;
      regAddrMiss_q <= (regRdEn || regWrEn) && !mapped;
      if (regRdEn) begin
        case (regAddr)
          `TREB_ADDR_SET: regRdData_q <= setReadback;
          `TREB_ADDR_INDEX: regRdData_q <= trebleIndex_q;
          `TREB_ADDR_AM: regRdData_q <= amReg_q;
          default: regRdData_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Decoded outputs are registered so the audio path sees clean levels.
  // They trail the stored registers by one cycle; surroundAsLineout_q trails the sixChannelMode input by one cycle.
  always @(posedge clk) begin
    if (srst) begin
      trebleSet_q <= {4{`TREB_SET_RESET}};
      illegalSetWrite_q <= 1'b0;
      trebleGainDb_q <= 24'h000000;
      indexInvalid_q <= 4'h0;
      amUseRateConv_q <= 1'b0;
      amEnable_q <= 1'b0;
      amSequence_q <= 2'h0;
      amIfLow_q <= 1'b0;
      amBinaryTuned_q <= 1'b0;
      amTunedField_q <= 16'h0000;
      amTunedKhz_q <= 11'h000;
      amDigitsValid_q <= 1'b1;
      surroundAsLineout_q <= 1'b0;
    end else begin
      trebleSet_q <= setSel;
      illegalSetWrite_q <= |setIllegal;
      trebleGainDb_q <= gainDb;
      indexInvalid_q <= gainBad;
      amUseRateConv_q <= amReg_q[`TREB_AM_METHOD_BIT];
      amEnable_q <= amReg_q[`TREB_AM_ENABLE_BIT];
      amSequence_q <= amReg_q[`TREB_AM_SEQ_HI:`TREB_AM_SEQ_LO];
      amIfLow_q <= amReg_q[`TREB_AM_IF_BIT];
      amBinaryTuned_q <= amReg_q[`TREB_AM_BINARY_BIT];
      amTunedField_q <= amReg_q[15:0];
      amTunedKhz_q <= khzNext;
      amDigitsValid_q <= digitsOkNext;
      surroundAsLineout_q <= sixChannelMode;
    end
  end

endmodule // treb_config

// ==== treb_map.vh ====
`ifndef TREB_MAP_VH
`define TREB_MAP_VH

// Subaddresses of the serial control port.
`define TREB_ADDR_SET 8'hDC
`define TREB_ADDR_INDEX 8'hDD
`define TREB_ADDR_AM 8'hDE

// Channel group layout shared by the set and index registers.
`define TREB_GROUPS 4
`define TREB_GROUP_W 8
`define TREB_SET_CODE_W 3

// Set selector codes.
`define TREB_SET_KEEP 3'h0
`define TREB_SET_LAST 3'h5
`define TREB_SET_RESET 3'h1

// Gain index values.
`define TREB_INDEX_RESET 32'h12121212
`define TREB_INDEX_MAX 8'h24
`define TREB_INDEX_TOP_DB 8'h12

// Am_avoidance_mode layout and reset.
`define TREB_AM_RESET 32'h00000000
`define TREB_AM_METHOD_BIT 24
`define TREB_AM_ENABLE_BIT 20
`define TREB_AM_SEQ_HI 19
`define TREB_AM_SEQ_LO 18
`define TREB_AM_IF_BIT 17
`define TREB_AM_BINARY_BIT 16
`define TREB_AM_THOUSANDS_BIT 12
`define TREB_AM_HUNDREDS_LO 8
`define TREB_AM_TENS_LO 4
`define TREB_AM_UNITS_LO 0
`define TREB_AM_BIN_HI 10
`define TREB_AM_BCD_MASK 16'h1FFF
`define TREB_AM_BIN_MASK 16'h07FF
`define TREB_BCD_MAX_DIGIT 4'h9

`endif

// ==== treb_set_field.v ====
`timescale 1ns/1ps
`include "treb_map.vh"

module treb_set_field (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Write side
  input wire wrEn,
  input wire [2:0] code,
  // State
  output reg [2:0] setSel_q,
  output reg illegal_q
);

  wire isKeep;
  wire isIllegal;

  assign isKeep = (code == `TREB_SET_KEEP);
  assign isIllegal = (code > `TREB_SET_LAST);

  always @(posedge clk) begin
    if (srst) begin
      setSel_q <= `TREB_SET_RESET;
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= wrEn && isIllegal;
      // Zero and illegal codes both leave the active set alone.
      if (wrEn && !isKeep && !isIllegal) begin
        setSel_q <= code;
      end
    end
  end

endmodule // treb_set_field

// ==== treb_config_asserts.sv ====
`timescale 1ns/1ps
module treb_config_asserts (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register access
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  input wire regRdValid_q,
  input wire regAddrMiss_q,
  // Decoded state
  input wire sixChannelMode,
  input wire surroundAsLineout_q,
  input wire [11:0] trebleSet_q,
  input wire illegalSetWrite_q,
  input wire [31:0] trebleIndex_q,
  input wire [23:0] trebleGainDb_q,
  input wire [3:0] indexInvalid_q,
  input wire amUseRateConv_q,
  input wire amEnable_q,
  input wire [1:0] amSequence_q,
  input wire [10:0] amTunedKhz_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire wrSet = regWrEn && regAddr == 8'hDC;
  wire wrIdx = regWrEn && regAddr == 8'hDD;
  wire wrAm = regWrEn && regAddr == 8'hDE;
  wire unmapped = regAddr < 8'hDC || regAddr > 8'hDE;
  idx_reset_a: assert property ($past(srst) |-> trebleIndex_q == 32'h12121212)
    else $error("index not at reset value");
  idx_write_a: assert property (wrIdx |=> trebleIndex_q == $past(regWrData))
    else $error("index write lost");
  gain_map_a: assert property (!$past(srst) && $past(trebleIndex_q[7:0]) <= 8'h24 |->
    trebleGainDb_q[5:0] == 6'h12 - $past(trebleIndex_q[5:0])) else $error("gain mismatch");
  idx_clamp_a: assert property (trebleIndex_q[7:0] > 8'h24 |=>
    indexInvalid_q[0] && trebleGainDb_q[5:0] == 6'h2E) else $error("bad index not flagged");
  set_select_a: assert property (wrSet && regWrData[2:0] != 3'h0 && regWrData[2:1] != 2'b11
    |=> ##1 trebleSet_q[2:0] == $past(regWrData[2:0], 2)) else $error("set not selected");
  set_keep_a: assert property (wrSet && !$past(regWrEn) && regWrData[2:0] == 3'h0
    |=> ##1 $stable(trebleSet_q[2:0])) else $error("set changed on keep");
  set_illegal_a: assert property (wrSet && regWrData[2:1] == 2'b11 |=> ##1 illegalSetWrite_q)
    else $error("illegal set not flagged");
  am_fields_a: assert property (wrAm |=> ##1 {amUseRateConv_q, amEnable_q, amSequence_q} ==
    {$past(regWrData[24], 2), $past(regWrData[20:18], 2)}) else $error("AM fields wrong");
  am_binary_a: assert property (wrAm && regWrData[16] |=> ##1
    amTunedKhz_q == $past(regWrData[10:0], 2)) else $error("binary tuning wrong");
  rd_valid_a: assert property (!$past(srst) |-> regRdValid_q == $past(regRdEn))
    else $error("read valid wrong");
  addr_miss_a: assert property ((regWrEn || regRdEn) && unmapped |=> regAddrMiss_q)
    else $error("miss not flagged");
  lineout_a: assert property (!$past(srst) |-> surroundAsLineout_q == $past(sixChannelMode))
    else $error("lineout copy wrong");
endmodule // treb_config_asserts
bind treb_config treb_config_asserts chk (.clk, .srst, .regAddr, .regWrData, .regWrEn, .regRdEn,
  .regRdValid_q, .regAddrMiss_q, .sixChannelMode, .surroundAsLineout_q, .trebleSet_q,
  .illegalSetWrite_q,
  .trebleIndex_q, .trebleGainDb_q, .indexInvalid_q, .amUseRateConv_q, .amEnable_q,
  .amSequence_q, .amTunedKhz_q);

// ==== treb_host_model.sv ====
`timescale 1ns/1ps
module treb_host_model (
  // Clock
  input wire clk,
  // Register port
  output logic [7:0] regAddr = 8'h00,
  output logic [31:0] regWrData = 32'h00000000,
  output logic regWrEn = 1'b0,
  output logic regRdEn = 1'b0,
  input wire [31:0] regRdData_q
);
  // Callers keep index bytes at or below 0x24 unless an invalid value is wanted.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(posedge clk);
    d = regRdData_q;
  endtask
endmodule // treb_host_model

// ==== treb_config_test.sv ====
`timescale 1ns/1ps
module treb_config_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sixChannelMode = 1'b0;
  logic [31:0] d;
  wire [7:0] regAddr;
  wire [31:0] regWrData, regRdData_q, trebleIndex_q;
  wire regWrEn, regRdEn, regRdValid_q, regAddrMiss_q, surroundAsLineout_q, illegalSetWrite_q;
  wire [11:0] trebleSet_q;
  wire [23:0] trebleGainDb_q;
  wire [3:0] indexInvalid_q;
  wire amUseRateConv_q, amEnable_q, amIfLow_q, amBinaryTuned_q, amDigitsValid_q;
  wire [1:0] amSequence_q;
  wire [15:0] amTunedField_q;
  wire [10:0] amTunedKhz_q;
  int fails = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  treb_config dut (.clk, .srst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData_q,
    .regRdValid_q, .regAddrMiss_q, .sixChannelMode, .surroundAsLineout_q, .trebleSet_q,
    .illegalSetWrite_q, .trebleIndex_q, .trebleGainDb_q, .indexInvalid_q, .amUseRateConv_q,
    .amEnable_q, .amSequence_q, .amIfLow_q, .amBinaryTuned_q, .amTunedField_q, .amTunedKhz_q,
    .amDigitsValid_q);
  treb_host_model host (.clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData_q);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_reset;
    host.rd(8'hDD, d);
    chk(d, 32'h12121212);
    chk(trebleSet_q, 12'h249);
    host.rd(8'hDE, d);
    chk(d, 32'h00000000);
  endtask
  task automatic t_index;
    host.wr(8'hDD, 32'h00122400);
    settle(2);
    chk(trebleGainDb_q, 24'h480B92);
    host.rd(8'hDD, d);
    chk(d, 32'h00122400);
    host.wr(8'hDD, 32'h12121225);
    settle(2);
    chk({indexInvalid_q, trebleGainDb_q[5:0]}, 10'h06E);
  endtask
  task automatic t_set;
    host.wr(8'hDC, 32'h02000305);
    settle(2);
    chk(trebleSet_q, 12'h45D);
    host.wr(8'hDC, 32'h00060007);
    settle(1);
    chk(illegalSetWrite_q, 1'b1);
    host.wr(8'hDC, 32'h00000000);
    settle(2);
    chk(trebleSet_q, 12'h45D);
    host.rd(8'hDC, d);
    chk(d, 32'h02010305);
    @(posedge clk) sixChannelMode <= 1'b1;
    settle(2);
    chk(surroundAsLineout_q, 1'b1);
  endtask
  task automatic t_am;
    logic [31:0] w[4] = '{32'h811E1620, 32'h000107FF, 32'h00141099, 32'h000000A0};
    logic [10:0] khz[4] = '{11'h654, 11'h7FF, 11'h44B, 11'h000};
    logic [15:0] f;
    for (int i = 0; i < 4; i++) begin
      host.wr(8'hDE, w[i]);
      settle(2);
      f = w[i][15:0] & (w[i][16] ? 16'h07FF : 16'h1FFF);
      chk({amUseRateConv_q, amEnable_q, amSequence_q, amIfLow_q, amBinaryTuned_q},
        {w[i][24], w[i][20:16]});
      chk(amTunedField_q, f);
      chk(amDigitsValid_q, i < 3);
      if (i < 3) chk(amTunedKhz_q, khz[i]);
      host.rd(8'hDE, d);
      chk(d, {w[i][31:16] & 16'h011F, f});
    end
  endtask
  // A second reset in mid-run must bring the index and set registers back to their reset values.
  task automatic t_rerun;
    @(posedge clk) srst <= 1'b1;
    settle(2);
    chk({surroundAsLineout_q, trebleSet_q, indexInvalid_q}, 17'h02490);
    chk({amDigitsValid_q, amTunedKhz_q}, 12'h800);
    @(posedge clk) srst <= 1'b0;
    host.rd(8'hDD, d);
    chk(d, 32'h12121212);
    chk(trebleGainDb_q, 24'h000000);
    host.rd(8'hDC, d);
    chk(d, 32'h01010101);
  endtask
  task automatic t_miss;
    for (int a = 'h89; a <= 'h90; a++) begin
      host.wr(a[7:0], 32'h00000000);
      #1 chk(regAddrMiss_q, 1'b1);
    end
    host.rd(8'h90, d);
    chk(d, 32'h00000000);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_miss();
    t_index();
    t_set();
    t_am();
    t_rerun();
    final_report();
  end
  // The whole sequence needs about a hundred cycles; this leaves wide margin.
  initial begin
    #100000;
    fails++;
    final_report();
  end
endmodule // treb_config_test
